// file: inc/nsl_pkg.sv
/*
  Constants for the NMI source logic: I/O port addresses, bit positions
  of status and enable fields, reset values and timing counts.
  Assumes a 200 MHz system clock and 16-bit I/O port addresses.
*/
// Operation
// - Parity error input latches its own flag
// - System error input is an NMI source
// - Expansion check low level latches a flag
// - Fail-safe terminal count raises an NMI source
// - Preempted master holding request 64 clocks times out
// - Command held beyond 256 clocks times out
// - DMA transfers never cause a bus timeout
// - Bus timeout also drives expansion bus reset
// - Any write to trigger port sets software source
// - Four 8-bit I/O mapped registers
// - Port 61 bits 7,6 status; 2,3 enables
// - Port 461 bits 7,6,5 status; 2,3,1 enables
// - Disabling a source clears its flag
// - Port 70 bit 7 gates all, keeps flags
// - Re-enabling with pending flags reasserts NMI
// - NMI is a level; disable-enable makes an edge
package nsl_pkg;

  // Port addresses
  localparam logic [15:0] PORT_STATUS = 16'h0061;
  localparam logic [15:0] PORT_MASTER = 16'h0070;
  localparam logic [15:0] PORT_EXT = 16'h0461;
  localparam logic [15:0] PORT_SWTRIG = 16'h0462;

  // Status port fields
  localparam int unsigned STS_PERR_BIT = 7;
  localparam int unsigned STS_IOCHK_BIT = 6;
  localparam int unsigned EN_IOCHK_BIT = 3;
  localparam int unsigned EN_PERR_BIT = 2;

  // Extended port fields
  localparam int unsigned EXT_FS_BIT = 7;
  localparam int unsigned EXT_TO_BIT = 6;
  localparam int unsigned EXT_SW_BIT = 5;
  localparam int unsigned EN_TO_BIT = 3;
  localparam int unsigned EN_FS_BIT = 2;
  localparam int unsigned EN_SW_BIT = 1;

  // Master port field
  localparam int unsigned MST_DIS_BIT = 7;

  // Reset values
  localparam logic [3:0] STATUS_CTL_RST = 4'h0;
  localparam logic [2:0] EXT_EN_RST = 3'h0;
  localparam logic [7:0] MASTER_RST = 8'h80;

  // Source flag indices
  localparam int unsigned SRC_PERR = 0;
  localparam int unsigned SRC_SERR = 1;
  localparam int unsigned SRC_IOCHK = 2;
  localparam int unsigned SRC_FS = 3;
  localparam int unsigned SRC_TO = 4;
  localparam int unsigned SRC_SW = 5;
  localparam int unsigned SRC_COUNT = 6;

  // Bus timeout limits in bus clocks
  localparam int unsigned PREEMPT_BCLKS = 64;
  localparam int unsigned CMD_MAX_BCLKS = 256;
  localparam int unsigned WATCH_W = 9;

  // Expansion bus reset pulse length
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned RESDRV_HOLD_NS = 1000;
  localparam int unsigned RESDRV_HOLD_CYC = (RESDRV_HOLD_NS * CLK_MHZ) / 1000;
  localparam int unsigned RESDRV_W = 8;

endpackage

// file: hw/nsl_bus_watch.sv
/*
  Bus clock watchdog: counts bus clock ticks while a condition holds
  and pulses once when the count reaches its limit.
  Assumes tick is a one-cycle pulse already in the system clock domain.
*/
`timescale 1ns/100ps
module nsl_bus_watch #(
  parameter int unsigned LIMIT = 64
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Condition and bus clock tick
  input wire logic tick,
  input wire logic arm,
  // One-cycle expiry pulse
  output logic expired
);

  logic [nsl_pkg::WATCH_W-1:0] cnt_reg;
  logic [nsl_pkg::WATCH_W-1:0] cnt_next;
  logic fired_reg;
  logic hit;

  // Fire once per condition so a stuck bus does not retrigger every tick
  assign hit = arm && tick && !fired_reg &&
               (cnt_reg == nsl_pkg::WATCH_W'(LIMIT - 1));
  assign cnt_next = !arm ? '0 :
                    (tick && !fired_reg) ? cnt_reg + 1'b1 : cnt_reg;

  // Counter, once-only latch and registered pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      fired_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      fired_reg <= arm && (fired_reg || hit);
      expired <= hit;
    end
  end

endmodule

// file: hw/nsl_nmi_logic.sv
/*
  NMI source logic: detect flags for hardware and software error
  sources, enables (system error shares the parity enable), master gate and a level NMI output,
  with four byte-wide I/O ports. Also drives the expansion bus reset
  on a bus timeout.
  Assumes I/O strobes come from logic on ref_clk; all bus pins are
  asynchronous and are synchronised here.
*/
`timescale 1ns/100ps
module nsl_nmi_logic (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // I/O port access, same clock domain
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rd_valid,
  // Error source pins, asynchronous
  input wire logic perr_n,
  input wire logic serr_n,
  input wire logic iochk_n,
  // Expansion bus monitor pins, asynchronous
  input wire logic bclk,
  input wire logic mack_n,
  input wire logic mreq_n,
  input wire logic cmd_n,
  input wire logic chrdy,
  // Internal sources, same clock domain
  input wire logic dma_active,
  input wire logic failsafe_tc,
  // Outputs
  output logic nmi,
  output logic resdrv
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int unsigned NPIN = 8;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;

  // Order fixes which synchronised bit means what
  assign pin_raw = {bclk, chrdy, cmd_n, mreq_n, mack_n, iochk_n, serr_n, perr_n};

  // Two flops per pin; the first stage feeds only the second
  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_sync
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_reg[p] <= 1'b1;
          sync2_reg[p] <= 1'b1;
        end else begin
          sync1_reg[p] <= pin_raw[p];
          sync2_reg[p] <= sync1_reg[p];
        end
      end
    end
  endgenerate

  logic perr_s;
  logic serr_s;
  logic iochk_s;
  logic mack_neg_s;
  logic mreq_s;
  logic cmd_s;
  logic chrdy_s;
  logic bclk_s;

  // Active-high views of the synchronised pins
  assign perr_s = !sync2_reg[0];
  assign serr_s = !sync2_reg[1];
  assign iochk_s = !sync2_reg[2];
  assign mack_neg_s = sync2_reg[3];
  assign mreq_s = !sync2_reg[4];
  assign cmd_s = !sync2_reg[5];
  assign chrdy_s = sync2_reg[6];
  assign bclk_s = sync2_reg[7];

  ////////////////////////////////////////////////////////////////////////
  // Bus timeout detection

  logic bclk_prev_reg;
  logic bclk_tick;
  logic pre_arm;
  logic cmd_arm;
  logic pre_exp;
  logic cmd_exp;
  logic to_pulse;

  // Rising edge of the synchronised bus clock counts one bus clock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_prev_reg <= 1'b1;
    end else begin
      bclk_prev_reg <= bclk_s;
    end
  end
  assign bclk_tick = bclk_s && !bclk_prev_reg;

  // DMA cycles hold both watchdogs idle however long they run
  assign pre_arm = mack_neg_s && mreq_s && !dma_active;
  assign cmd_arm = cmd_s && !chrdy_s && !dma_active;

  nsl_bus_watch #(
    .LIMIT(nsl_pkg::PREEMPT_BCLKS)
  ) u_pre_watch (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick(bclk_tick),
    .arm(pre_arm),
    .expired(pre_exp)
  );

  // Command must stay out beyond the limit, so one tick more
  nsl_bus_watch #(
    .LIMIT(nsl_pkg::CMD_MAX_BCLKS + 1)
  ) u_cmd_watch (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick(bclk_tick),
    .arm(cmd_arm),
    .expired(cmd_exp)
  );

  assign to_pulse = pre_exp || cmd_exp;

  ////////////////////////////////////////////////////////////////////////
  // Expansion bus reset

  logic [nsl_pkg::RESDRV_W-1:0] rst_cnt_reg;
  logic [nsl_pkg::RESDRV_W-1:0] rst_cnt_next;

  // A timeout loads the hold count; it runs down to zero
  assign rst_cnt_next = to_pulse ? nsl_pkg::RESDRV_W'(nsl_pkg::RESDRV_HOLD_CYC) :
                        (rst_cnt_reg != '0) ? rst_cnt_reg - 1'b1 : rst_cnt_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_reg <= '0;
      resdrv <= 1'b0;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      resdrv <= (rst_cnt_next != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port decode and control registers

  logic wr_sts;
  logic wr_mst;
  logic wr_ext;
  logic wr_sw;
  logic rd_hit;
  logic [3:0] sts_ctl_reg;
  logic [2:0] ext_en_reg;
  logic [7:0] mst_reg;

  // Full 16-bit compare; other addresses are left to other blocks
  assign wr_sts = io_wr && (io_addr == nsl_pkg::PORT_STATUS);
  assign wr_mst = io_wr && (io_addr == nsl_pkg::PORT_MASTER);
  assign wr_ext = io_wr && (io_addr == nsl_pkg::PORT_EXT);
  assign wr_sw = io_wr && (io_addr == nsl_pkg::PORT_SWTRIG);
  assign rd_hit = io_rd && (io_addr == nsl_pkg::PORT_STATUS ||
                            io_addr == nsl_pkg::PORT_MASTER ||
                            io_addr == nsl_pkg::PORT_EXT);

  // Writable fields; the trigger port stores nothing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sts_ctl_reg <= nsl_pkg::STATUS_CTL_RST;
      ext_en_reg <= nsl_pkg::EXT_EN_RST;
      mst_reg <= nsl_pkg::MASTER_RST;
    end else begin
      if (wr_sts) begin
        sts_ctl_reg <= io_wdata[3:0];
      end
      if (wr_ext) begin
        ext_en_reg <= io_wdata[3:1];
      end
      if (wr_mst) begin
        mst_reg <= io_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Detect flags

  logic [nsl_pkg::SRC_COUNT-1:0] src;
  logic [nsl_pkg::SRC_COUNT-1:0] en;
  logic [nsl_pkg::SRC_COUNT-1:0] clr;
  logic [nsl_pkg::SRC_COUNT-1:0] flag_reg;
  logic [nsl_pkg::SRC_COUNT-1:0] flag_next;
  logic perr_en;
  logic iochk_en;
  logic fs_en;
  logic to_en;
  logic sw_en;

  assign perr_en = sts_ctl_reg[nsl_pkg::EN_PERR_BIT];
  assign iochk_en = sts_ctl_reg[nsl_pkg::EN_IOCHK_BIT];
  assign fs_en = ext_en_reg[nsl_pkg::EN_FS_BIT-1];
  assign to_en = ext_en_reg[nsl_pkg::EN_TO_BIT-1];
  assign sw_en = ext_en_reg[nsl_pkg::EN_SW_BIT-1];

  // Source conditions; system error shares the parity enable
  assign src = {wr_sw, to_pulse, failsafe_tc, iochk_s, serr_s, perr_s};
  assign en = {sw_en, to_en, fs_en, iochk_en, perr_en, perr_en};

  // Writing an enable to zero clears its flag
  assign clr = {wr_ext && !io_wdata[nsl_pkg::EN_SW_BIT],
                wr_ext && !io_wdata[nsl_pkg::EN_TO_BIT],
                wr_ext && !io_wdata[nsl_pkg::EN_FS_BIT],
                wr_sts && !io_wdata[nsl_pkg::EN_IOCHK_BIT],
                wr_sts && !io_wdata[nsl_pkg::EN_PERR_BIT],
                wr_sts && !io_wdata[nsl_pkg::EN_PERR_BIT]};

  // A set in the same cycle as a clear wins, so no event is lost
  assign flag_next = (src & en) | (flag_reg & ~clr);

  generate
    for (genvar s = 0; s < nsl_pkg::SRC_COUNT; s++) begin : g_flag
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          flag_reg[s] <= 1'b0;
        end else begin
          flag_reg[s] <= flag_next[s];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // NMI output and read data

  logic nmi_next;
  logic [7:0] sts_rd;
  logic [7:0] ext_rd;
  logic [7:0] rd_mux;

  // Master gate does not touch flags, so re-enabling reasserts the level
  assign nmi_next = !mst_reg[nsl_pkg::MST_DIS_BIT] && |(flag_reg & en);

  assign sts_rd = {flag_reg[nsl_pkg::SRC_PERR] | flag_reg[nsl_pkg::SRC_SERR],
                   flag_reg[nsl_pkg::SRC_IOCHK], 2'b00, sts_ctl_reg};
  assign ext_rd = {flag_reg[nsl_pkg::SRC_FS], flag_reg[nsl_pkg::SRC_TO],
                   flag_reg[nsl_pkg::SRC_SW], 1'b0, ext_en_reg, 1'b0};
  assign rd_mux = (io_addr == nsl_pkg::PORT_STATUS) ? sts_rd :
                  (io_addr == nsl_pkg::PORT_EXT) ? ext_rd :
                  (io_addr == nsl_pkg::PORT_MASTER) ? mst_reg : 8'h00;

  // Read data is held until the next read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi <= 1'b0;
      io_rdata <= 8'h00;
      io_rd_valid <= 1'b0;
    end else begin
      nmi <= nmi_next;
      io_rd_valid <= rd_hit;
      if (io_rd) begin
        io_rdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  parity_flag_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (perr_s && perr_en) |=> flag_reg[nsl_pkg::SRC_PERR])
    else $error("parity flag not set");
  system_flag_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (serr_s && perr_en) |=> sts_rd[nsl_pkg::STS_PERR_BIT])
    else $error("system error flag not set");
  iochk_flag_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (iochk_s && iochk_en) |=> flag_reg[nsl_pkg::SRC_IOCHK])
    else $error("expansion check flag not set");
  failsafe_flag_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (failsafe_tc && fs_en) |=> ext_rd[nsl_pkg::EXT_FS_BIT])
    else $error("fail-safe flag not set");
  preempt_timeout_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (pre_exp && to_en) |=> flag_reg[nsl_pkg::SRC_TO] && resdrv)
    else $error("preempt timeout not flagged");
  cmd_timeout_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    cmd_exp |-> $past(cmd_arm))
    else $error("command timeout without held command");
  dma_no_timeout_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $past(dma_active) |-> !to_pulse)
    else $error("timeout during dma");
  resdrv_hold_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    to_pulse |=> resdrv [*8])
    else $error("bus reset too short");
  // A disabling write right after the trigger may legally drop the flag
  sw_trigger_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (wr_sw && sw_en) |=> flag_reg[nsl_pkg::SRC_SW] ##1
      (flag_reg[nsl_pkg::SRC_SW] || $past(clr[nsl_pkg::SRC_SW])))
    else $error("software trigger lost");
  sw_clear_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (wr_ext && !io_wdata[nsl_pkg::EN_SW_BIT]) |=> !flag_reg[nsl_pkg::SRC_SW])
    else $error("disable did not clear flag");
  master_keep_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_mst |=> flag_reg == $past(flag_reg | (src & en)))
    else $error("master write changed flags");
  master_gate_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    mst_reg[nsl_pkg::MST_DIS_BIT] |=> !nmi)
    else $error("nmi while master disabled");
  reassert_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!mst_reg[nsl_pkg::MST_DIS_BIT] && |(flag_reg & en)) |=> nmi)
    else $error("nmi not asserted with pending source");
  status_read_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (io_rd && io_addr == nsl_pkg::PORT_STATUS) |=>
      io_rdata[nsl_pkg::STS_IOCHK_BIT] == $past(flag_reg[nsl_pkg::SRC_IOCHK]))
    else $error("status read wrong");

endmodule

// file: tb/nsl_host_model.sv
/*
  Far-side model: the host processor NMI input, which counts rising edges,
  and the free-running expansion bus clock.
  Assumes ref_clk at 200 MHz; the bus clock half period is set in ref_clk cycles.
*/
`timescale 1ns/100ps
module nsl_host_model #(
  parameter int unsigned BCLK_HALF = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Processor NMI pin
  input wire logic nmi,
  // Bus clock and seen NMI edges
  output logic bclk,
  output logic [7:0] nmi_edges
);
  logic [4:0] div_reg;
  logic nmi_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus clock runs free, also between bus cycles
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 5'h00;
      bclk <= 1'b0;
    end else if (div_reg == 5'(BCLK_HALF - 1)) begin
      div_reg <= 5'h00;
      bclk <= ~bclk;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  // The processor only registers a rising edge; a held level is missed
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_reg <= 1'b0;
      nmi_edges <= 8'h00;
    end else begin
      nmi_reg <= nmi;
      if (nmi && !nmi_reg) begin
        nmi_edges <= nmi_edges + 8'h01;
      end
    end
  end
endmodule

// file: tb/nsl_nmi_logic_tb.sv
/*
  Self-checking bench for the NMI source logic: I/O port tasks, error pin
  pulses, fail-safe pulse and bus timeout episodes.
  Assumes the host model supplies the bus clock and counts NMI edges.
*/
`timescale 1ns/100ps
module nsl_nmi_logic_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic io_rd_valid;
  logic [2:0] pins_n = 3'h7;
  logic mack_n = 1'b1;
  logic mreq_n = 1'b1;
  logic cmd_n = 1'b1;
  logic chrdy = 1'b1;
  logic dma_active = 1'b0;
  logic failsafe_tc = 1'b0;
  logic nmi;
  logic resdrv;
  logic bclk;
  logic [7:0] nmi_edges;
  int mismatches = 0;
  int samples_checked = 0;
  logic [7:0] pin_exp [3] = '{8'h8C, 8'h8C, 8'h4C};

  always #2.5 ref_clk = ~ref_clk;

  nsl_nmi_logic i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid),
    .perr_n(pins_n[0]), .serr_n(pins_n[1]), .iochk_n(pins_n[2]), .bclk(bclk),
    .mack_n(mack_n), .mreq_n(mreq_n), .cmd_n(cmd_n), .chrdy(chrdy),
    .dma_active(dma_active), .failsafe_tc(failsafe_tc), .nmi(nmi), .resdrv(resdrv)
  );

  nsl_host_model i_host (
    .ref_clk(ref_clk), .reset_n(reset_n), .nmi(nmi), .bclk(bclk), .nmi_edges(nmi_edges)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic bc(input int n);
    repeat (n) @(posedge bclk);
    #1;
  endtask

  // Write is taken at the second edge, one strobe cycle per access
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge ref_clk);
    io_wr <= 1'b0;
  endtask

  // Read data and valid are looked at just after the taking edge, while valid stands
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic vld);
    @(posedge ref_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge ref_clk);
    io_rd <= 1'b0;
    #1;
    chk(io_rdata, exp);
    chk({7'h00, io_rd_valid}, {7'h00, vld});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(16'h0070, 8'h80, 1'b1);
    rd(16'h0061, 8'h00, 1'b1);
    rd(16'h0461, 8'h00, 1'b1);
    rd(16'h0063, 8'h00, 1'b0);
    rd(16'h0462, 8'h00, 1'b0);
    // A source seen while disabled must not latch
    @(posedge ref_clk) failsafe_tc <= 1'b1;
    @(posedge ref_clk) failsafe_tc <= 1'b0;
    rd(16'h0461, 8'h00, 1'b1);
    wr(16'h0061, 8'h0C);
    wr(16'h0461, 8'h0E);
    wr(16'h0070, 8'h00);
    rd(16'h0061, 8'h0C, 1'b1);
    rd(16'h0461, 8'h0E, 1'b1);
    // Software trigger, data ignored, then master gate toggling
    wr(16'h0462, 8'hA5);
    rd(16'h0461, 8'h2E, 1'b1);
    chk({7'h00, nmi}, 8'h01);
    chk(nmi_edges, 8'h01);
    wr(16'h0070, 8'h80);
    cyc(3);
    chk({7'h00, nmi}, 8'h00);
    rd(16'h0461, 8'h2E, 1'b1);
    wr(16'h0070, 8'h00);
    cyc(3);
    chk({7'h00, nmi}, 8'h01);
    chk(nmi_edges, 8'h02);
    wr(16'h0461, 8'h0C);
    cyc(3);
    chk({7'h00, nmi}, 8'h00);
    rd(16'h0461, 8'h0C, 1'b1);
    wr(16'h0461, 8'h0E);
    // Error pins: parity, system error, expansion check
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk) pins_n[i] <= 1'b0;
      cyc(4);
      @(posedge ref_clk) pins_n[i] <= 1'b1;
      cyc(4);
      rd(16'h0061, pin_exp[i], 1'b1);
      wr(16'h0061, 8'h00);
      rd(16'h0061, 8'h00, 1'b1);
      wr(16'h0061, 8'h0C);
    end
    // Fail-safe terminal count
    @(posedge ref_clk) failsafe_tc <= 1'b1;
    @(posedge ref_clk) failsafe_tc <= 1'b0;
    rd(16'h0461, 8'h8E, 1'b1);
    wr(16'h0461, 8'h0A);
    rd(16'h0461, 8'h0A, 1'b1);
    wr(16'h0461, 8'h0E);
    // Master not preempted and slave ready: neither watchdog may fire
    @(posedge ref_clk) begin
      mack_n <= 1'b0;
      mreq_n <= 1'b0;
      cmd_n <= 1'b0;
    end
    bc(270);
    chk({7'h00, resdrv}, 8'h00);
    rd(16'h0461, 8'h0E, 1'b1);
    @(posedge ref_clk) begin
      mack_n <= 1'b1;
      mreq_n <= 1'b1;
      cmd_n <= 1'b1;
    end
    // Preempted master keeps its request; margins cover synchroniser delay
    @(posedge ref_clk) mreq_n <= 1'b0;
    bc(60);
    chk({7'h00, resdrv}, 8'h00);
    bc(8);
    chk({7'h00, resdrv}, 8'h01);
    @(posedge ref_clk) mreq_n <= 1'b1;
    rd(16'h0461, 8'h4E, 1'b1);
    cyc(220);
    chk({7'h00, resdrv}, 8'h00);
    wr(16'h0461, 8'h06);
    wr(16'h0461, 8'h0E);
    // Stretched command, first owned by DMA, then by a slave
    @(posedge ref_clk) begin
      dma_active <= 1'b1;
      cmd_n <= 1'b0;
      chrdy <= 1'b0;
    end
    bc(270);
    chk({7'h00, resdrv}, 8'h00);
    rd(16'h0461, 8'h0E, 1'b1);
    @(posedge ref_clk) dma_active <= 1'b0;
    bc(250);
    chk({7'h00, resdrv}, 8'h00);
    bc(12);
    chk({7'h00, resdrv}, 8'h01);
    @(posedge ref_clk) begin
      cmd_n <= 1'b1;
      chrdy <= 1'b1;
    end
    rd(16'h0461, 8'h4E, 1'b1);
    complete_run();
  end

  // Watchdog sized well above the expected run of about 22000 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end
endmodule
